// File: hw/oam_unit.sv
`timescale 1ns/1ns
module oam_unit (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  go,
  input  wire logic                  mem_ack,
  input  wire logic [15:0]           mem_rdata,
  output oam_pkg::oam_mem_req_t      mem_o_q,
  output logic                       busy_q,
  output logic                       done_q,
  output logic                       bad_op_q
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_FRD   = 4'h1,
    ST_FETCH = 4'h3,
    ST_SRD   = 4'h2,
    ST_EVAL  = 4'h6,
    ST_XRD   = 4'h7,
    ST_XPC   = 4'h5,
    ST_DEFER = 4'h4,
    ST_OPND  = 4'hC,
    ST_EXEC  = 4'hD,
    ST_WB    = 4'hF,
    ST_DONE  = 4'hE
  } oam_state_t;

  oam_state_t          st_q;
  logic [15:0]         ir_q;
  logic                spec_sel_q;
  logic                two_op_q;
  logic                byte_q;
  oam_pkg::oam_op_t    op_q;
  logic [15:0]         ea_q;
  logic [15:0]         base_q;
  logic [15:0]         src_q;
  logic [15:0]         dst_q;
  logic [15:0]         dst_ea_q;
  logic                dst_is_reg_q;
  logic [2:0]          dst_reg_q;
  oam_pkg::oam_rf_wr_t rf_wr_q;
  logic [2:0]          rf_raddr;
  logic [15:0]         rf_rdata;
  logic [15:0]         alu_result;
  logic [5:0]          spec;
  logic [2:0]          mode;
  logic [2:0]          rsel;
  logic [15:0]         step;
  logic                ack_take;
  logic [15:0]         opnd_val;

  // Opcode decode into an operation
  function automatic oam_pkg::oam_op_t decode_op(input logic [15:0] ir);
    if (ir[14:12] == oam_pkg::OPC_ADD && !ir[oam_pkg::BYTE_BIT]) begin
      return oam_pkg::OP_ADD;
    end else if (ir[14:12] == oam_pkg::OPC_MOV) begin
      return oam_pkg::OP_MOV;
    end else if (ir[14:12] == 3'h0 && ir[11:6] == oam_pkg::OPC_CLR) begin
      return oam_pkg::OP_CLR;
    end else if (ir[14:12] == 3'h0 && ir[11:6] == oam_pkg::OPC_COM) begin
      return oam_pkg::OP_COM;
    end else if (ir[14:12] == 3'h0 && ir[11:6] == oam_pkg::OPC_INC) begin
      return oam_pkg::OP_INC;
    end
    return oam_pkg::OP_BAD;
  endfunction

  // Step size for auto increment and decrement
  function automatic logic [15:0] step_of(input logic bop, input logic [2:0] r,
                                          input logic defer);
    if (bop && !defer && r != oam_pkg::SP_REG && r != oam_pkg::PC_REG) begin
      return oam_pkg::BYTE_STEP;
    end
    return oam_pkg::WORD_STEP;
  endfunction

  // Current specifier fields
  always_comb begin
    spec     = spec_sel_q ? ir_q[5:0] : ir_q[11:oam_pkg::SRC_LSB];
    mode     = spec[oam_pkg::MODE_MSB:oam_pkg::MODE_LSB];
    rsel     = spec[oam_pkg::REG_MSB:oam_pkg::REG_LSB];
    step     = step_of(byte_q, rsel, spec[oam_pkg::DEFER_BIT]);
    ack_take = mem_o_q.req && mem_ack;
    opnd_val = byte_q ? {8'h00, mem_rdata[7:0]} : mem_rdata;
  end

  // Register read address per state
  always_comb begin
    case (st_q)
      ST_FRD, ST_FETCH, ST_XRD, ST_XPC: rf_raddr = oam_pkg::PC_REG;
      ST_SRD, ST_EVAL:                  rf_raddr = rsel;
      default:                          rf_raddr = oam_pkg::PC_REG;
    endcase
  end

  oam_regfile u_regfile (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .raddr   (rf_raddr),
    .wr      (rf_wr_q),
    .rdata_q (rf_rdata)
  );

  oam_alu u_alu (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .op       (op_q),
    .src      (src_q),
    .dst      (dst_q),
    .result_q (alu_result)
  );

  // Sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE:  if (go) st_q <= ST_FRD;
        ST_FRD:   st_q <= ST_FETCH;
        ST_FETCH: if (ack_take) st_q <= ST_SRD;
        ST_SRD:   st_q <= ST_EVAL;
        ST_EVAL: begin
          case (mode)
            oam_pkg::MODE_REG:                      st_q <= ST_EXEC;
            oam_pkg::MODE_AIDF, oam_pkg::MODE_ADDF: st_q <= ST_DEFER;
            oam_pkg::MODE_IDX, oam_pkg::MODE_IXDF:  st_q <= ST_XRD;
            default:                                st_q <= ST_OPND;
          endcase
          if (mode == oam_pkg::MODE_REG && !spec_sel_q && two_op_q) begin
            st_q <= ST_SRD;
          end
        end
        ST_XRD:   st_q <= ST_XPC;
        ST_XPC:   if (ack_take) st_q <= spec[oam_pkg::DEFER_BIT] ? ST_DEFER : ST_OPND;
        ST_DEFER: if (ack_take) st_q <= ST_OPND;
        ST_OPND:  if (ack_take) st_q <= (!spec_sel_q && two_op_q) ? ST_SRD : ST_EXEC;
        ST_EXEC:  st_q <= ST_WB;
        ST_WB:    if (dst_is_reg_q || ack_take) st_q <= ST_DONE;
        ST_DONE:  st_q <= ST_IDLE;
        default:  st_q <= ST_IDLE;
      endcase
      if (st_q == ST_FETCH && ack_take && decode_op(mem_rdata) == oam_pkg::OP_BAD) begin
        st_q <= ST_DONE;
      end
    end
  end

  // Instruction latch and specifier selection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ir_q       <= oam_pkg::REG_RESET;
      op_q       <= oam_pkg::OP_BAD;
      two_op_q   <= 1'b0;
      byte_q     <= 1'b0;
      spec_sel_q <= 1'b0;
    end else if (st_q == ST_FETCH && ack_take) begin
      ir_q       <= mem_rdata;
      op_q       <= decode_op(mem_rdata);
      two_op_q   <= decode_op(mem_rdata) inside {oam_pkg::OP_ADD, oam_pkg::OP_MOV};
      byte_q     <= mem_rdata[oam_pkg::BYTE_BIT] && decode_op(mem_rdata) != oam_pkg::OP_ADD;
      spec_sel_q <= !(decode_op(mem_rdata) inside {oam_pkg::OP_ADD, oam_pkg::OP_MOV});
    end else if ((st_q == ST_OPND && ack_take) || (st_q == ST_EVAL && mode == 3'h0)) begin
      spec_sel_q <= 1'b1;
    end
  end

  // Register side effects and program counter stepping
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rf_wr_q <= '0;
    end else begin
      rf_wr_q <= '0;
      if ((st_q == ST_FETCH || st_q == ST_XPC) && ack_take) begin
        rf_wr_q <= '{we: 1'b1, low_only: 1'b0, addr: oam_pkg::PC_REG,
                     data: rf_rdata + oam_pkg::WORD_STEP};
      end else if (st_q == ST_EVAL) begin
        case (mode)
          oam_pkg::MODE_AINC, oam_pkg::MODE_AIDF: begin
            rf_wr_q <= '{we: 1'b1, low_only: 1'b0, addr: rsel,
                         data: rf_rdata + step};
          end
          oam_pkg::MODE_ADEC, oam_pkg::MODE_ADDF: begin
            rf_wr_q <= '{we: 1'b1, low_only: 1'b0, addr: rsel,
                         data: rf_rdata - step};
          end
          default: rf_wr_q <= '0;
        endcase
      end else if (st_q == ST_WB && dst_is_reg_q) begin
        rf_wr_q <= '{we: 1'b1, low_only: byte_q, addr: dst_reg_q,
                     data: alu_result};
      end
    end
  end

  // Effective address formation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ea_q   <= oam_pkg::REG_RESET;
      base_q <= oam_pkg::REG_RESET;
    end else if (st_q == ST_EVAL) begin
      base_q <= rf_rdata;
      case (mode)
        oam_pkg::MODE_ADEC, oam_pkg::MODE_ADDF: ea_q <= rf_rdata - step;
        default:                                ea_q <= rf_rdata;
      endcase
    end else if (st_q == ST_XPC && ack_take) begin
      if (rsel == oam_pkg::PC_REG) begin
        ea_q <= mem_rdata + rf_rdata + oam_pkg::WORD_STEP;
      end else begin
        ea_q <= mem_rdata + base_q;
      end
    end else if (st_q == ST_DEFER && ack_take) begin
      ea_q <= mem_rdata;
    end
  end

  // Operand capture for source and destination
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_q        <= oam_pkg::REG_RESET;
      dst_q        <= oam_pkg::REG_RESET;
      dst_ea_q     <= oam_pkg::REG_RESET;
      dst_is_reg_q <= 1'b0;
      dst_reg_q    <= 3'h0;
    end else if (st_q == ST_EVAL && mode == oam_pkg::MODE_REG) begin
      if (spec_sel_q) begin
        dst_q        <= byte_q ? {8'h00, rf_rdata[7:0]} : rf_rdata;
        dst_is_reg_q <= 1'b1;
        dst_reg_q    <= rsel;
      end else begin
        src_q <= byte_q ? {8'h00, rf_rdata[7:0]} : rf_rdata;
      end
    end else if (st_q == ST_OPND && ack_take) begin
      if (spec_sel_q) begin
        dst_q        <= opnd_val;
        dst_ea_q     <= ea_q;
        dst_is_reg_q <= 1'b0;
      end else begin
        src_q <= opnd_val;
      end
    end
  end

  // Memory request port
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_o_q <= '0;
    end else if (ack_take) begin
      mem_o_q.req <= 1'b0;
    end else if (!mem_o_q.req) begin
      case (st_q)
        ST_FETCH, ST_XPC: mem_o_q <= '{req: 1'b1, we: 1'b0, byte_en: 1'b0,
                                       addr: rf_rdata, wdata: 16'h0000};
        ST_DEFER: mem_o_q <= '{req: 1'b1, we: 1'b0, byte_en: 1'b0,
                               addr: ea_q, wdata: 16'h0000};
        ST_OPND:  mem_o_q <= '{req: 1'b1, we: 1'b0, byte_en: byte_q,
                               addr: ea_q, wdata: 16'h0000};
        ST_WB:    mem_o_q <= '{req: !dst_is_reg_q, we: 1'b1, byte_en: byte_q,
                               addr: dst_ea_q, wdata: alu_result};
        default:  mem_o_q <= '0;
      endcase
    end
  end

  // Status outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      bad_op_q <= 1'b0;
    end else begin
      busy_q <= (st_q != ST_IDLE || go) && st_q != ST_DONE;
      done_q <= st_q == ST_DONE;
      if (st_q == ST_FETCH && ack_take) begin
        bad_op_q <= decode_op(mem_rdata) == oam_pkg::OP_BAD;
      end
    end
  end

  property p_fetch_step;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_FETCH && ack_take) |=>
      (rf_wr_q.we && rf_wr_q.addr == 3'h7 && rf_wr_q.data == $past(mem_o_q.addr) + 16'h0002);
  endproperty
  a_fetch_step: assert property (p_fetch_step) else $error("pc not stepped by two");

  property p_postinc;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_EVAL && mode == 3'h2) |=> (rf_wr_q.we && rf_wr_q.data == ea_q +
      (($past(byte_q) && $past(rsel) < 3'h6) ? 16'h0001 : 16'h0002));
  endproperty
  a_postinc: assert property (p_postinc) else $error("bad autoincrement step");

  property p_predec;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_EVAL && mode == 3'h4) |=> (rf_wr_q.we && rf_wr_q.data == ea_q &&
      ea_q == $past(rf_rdata) - (($past(byte_q) && $past(rsel) < 3'h6) ? 16'h0001 : 16'h0002));
  endproperty
  a_predec: assert property (p_predec) else $error("decremented value not used");

  property p_defer_step;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_EVAL && (mode == 3'h3 || mode == 3'h5)) |=>
      (rf_wr_q.data - $past(rf_rdata) == 16'h0002 || $past(rf_rdata) - rf_wr_q.data == 16'h0002);
  endproperty
  a_defer_step: assert property (p_defer_step) else $error("deferred step not two");

  property p_reg_defer;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_EVAL && mode == 3'h1) |=> (!rf_wr_q.we && ea_q == $past(rf_rdata));
  endproperty
  a_reg_defer: assert property (p_reg_defer) else $error("register deferred wrong");

  property p_index_sum;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_XPC && ack_take) |=> (ea_q == $past(mem_rdata) +
      (($past(rsel) == 3'h7) ? $past(rf_rdata) + 16'h0002 : base_q));
  endproperty
  a_index_sum: assert property (p_index_sum) else $error("index address wrong");

  property p_pointer;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_DEFER && ack_take) |=> (ea_q == $past(mem_rdata) && st_q == ST_OPND);
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer word not used");

  property p_byte_reg;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_WB && dst_is_reg_q) |=> (rf_wr_q.we && rf_wr_q.low_only == $past(byte_q));
  endproperty
  a_byte_reg: assert property (p_byte_reg) else $error("byte write touched high byte");

  property p_src_first;
    @(posedge mclk) disable iff (!rst_n)
    (st_q == ST_OPND && ack_take && !spec_sel_q && two_op_q) |=> (st_q == ST_SRD && spec_sel_q);
  endproperty
  a_src_first: assert property (p_src_first) else $error("source not done first");

endmodule // oam_unit

// File: hw/oam_pkg.sv
package oam_pkg;

  // General register numbers and specifier layout
  localparam logic [2:0] SP_REG    = 3'h6;
  localparam logic [2:0] PC_REG    = 3'h7;
  localparam int         MODE_MSB  = 5;
  localparam int         MODE_LSB  = 3;
  localparam int         REG_MSB   = 2;
  localparam int         REG_LSB   = 0;
  localparam int         DEFER_BIT = 3;
  localparam int         SRC_LSB   = 6;
  localparam int         BYTE_BIT  = 15;

  // Address modes
  localparam logic [2:0] MODE_REG  = 3'h0;
  localparam logic [2:0] MODE_RDEF = 3'h1;
  localparam logic [2:0] MODE_AINC = 3'h2;
  localparam logic [2:0] MODE_AIDF = 3'h3;
  localparam logic [2:0] MODE_ADEC = 3'h4;
  localparam logic [2:0] MODE_ADDF = 3'h5;
  localparam logic [2:0] MODE_IDX  = 3'h6;
  localparam logic [2:0] MODE_IXDF = 3'h7;

  // Step sizes and reset values
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0]  BYTE_MASK = 8'hFF;

  // Opcode fields
  localparam logic [2:0] OPC_ADD  = 3'h6;
  localparam logic [2:0] OPC_MOV  = 3'h1;
  localparam logic [5:0] OPC_CLR  = 6'h28;
  localparam logic [5:0] OPC_COM  = 6'h29;
  localparam logic [5:0] OPC_INC  = 6'h2A;

  typedef enum logic [2:0] {
    OP_CLR, OP_COM, OP_INC, OP_MOV, OP_ADD, OP_BAD
  } oam_op_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } oam_mem_req_t;

  typedef struct packed {
    logic        we;
    logic        low_only;
    logic [2:0]  addr;
    logic [15:0] data;
  } oam_rf_wr_t;

endpackage

// File: hw/oam_regfile.sv
`timescale 1ns/1ns
module oam_regfile (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [2:0]         raddr,
  input  wire oam_pkg::oam_rf_wr_t wr,
  output logic      [15:0]        rdata_q
);

  logic [15:0] regs_q [8];
  logic [15:0] merged;

  // Write data merged with the old upper byte for byte writes
  always_comb begin
    merged = wr.low_only ? {regs_q[wr.addr][15:8], wr.data[7:0]} : wr.data;
  end

  // Storage of the eight general registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= oam_pkg::REG_RESET;
      end
    end else if (wr.we) begin
      regs_q[wr.addr] <= merged;
    end
  end

  // Registered read with write-first bypass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= oam_pkg::REG_RESET;
    end else if (wr.we && wr.addr == raddr) begin
      rdata_q <= merged;
    end else begin
      rdata_q <= regs_q[raddr];
    end
  end

endmodule // oam_regfile

// File: hw/oam_alu.sv
`timescale 1ns/1ns
module oam_alu (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire oam_pkg::oam_op_t op,
  input  wire logic [15:0]      src,
  input  wire logic [15:0]      dst,
  output logic      [15:0]      result_q
);

  // Registered combine of source and destination
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= oam_pkg::REG_RESET;
    end else begin
      case (op)
        oam_pkg::OP_CLR: result_q <= oam_pkg::REG_RESET;
        oam_pkg::OP_COM: result_q <= ~dst;
        oam_pkg::OP_INC: result_q <= dst + oam_pkg::BYTE_STEP;
        oam_pkg::OP_MOV: result_q <= src;
        oam_pkg::OP_ADD: result_q <= dst + src;
        default:         result_q <= dst;
      endcase
    end
  end

endmodule // oam_alu

// File: verif/oam_mem_model.sv
`timescale 1ns/1ns
module oam_mem_model (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire oam_pkg::oam_mem_req_t rq,
  output logic                       ack,
  output logic [15:0]                rdata
);
  logic [7:0]  bytes [0:65535];
  int          lat;
  int          cnt;
  logic [15:0] a0;
  logic [15:0] a1;

  // Word lanes of the addressed word
  assign a0 = {rq.addr[15:1], 1'b0};
  assign a1 = {rq.addr[15:1], 1'b1};

  // Empty memory, prompt answers
  initial begin
    lat = 0;
    for (int i = 0; i < 65536; i++) bytes[i] = 8'h00;
  end

  // One answer per request after lat wait cycles; data churns when idle
  always @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack   <= 1'b0;
      cnt   <= 0;
      rdata <= 16'h5A5A;
    end else if (!ack && rq.req && cnt >= lat) begin
      ack <= 1'b1;
      cnt <= 0;
      if (rq.we && rq.byte_en) begin
        bytes[rq.addr] <= rq.wdata[7:0];
      end else if (rq.we) begin
        bytes[a0] <= rq.wdata[7:0];
        bytes[a1] <= rq.wdata[15:8];
      end
      if (rq.byte_en) rdata <= {~bytes[rq.addr], bytes[rq.addr]};
      else rdata <= {bytes[a1], bytes[a0]};
    end else begin
      ack   <= 1'b0;
      cnt   <= rq.req ? cnt + 1 : 0;
      rdata <= ~rdata;
    end
  end
endmodule // oam_mem_model

// File: verif/tb_oam_unit.sv
`timescale 1ns/1ns
module tb_oam_unit;
  logic                  mclk;
  logic                  rst_n;
  logic                  go;
  logic                  mem_ack;
  logic [15:0]           mem_rdata;
  oam_pkg::oam_mem_req_t mem_o_q;
  logic                  busy_q;
  logic                  done_q;
  logic                  bad_op_q;
  int                    errors;
  int                    checks_done;
  logic [15:0]           pc;
  localparam logic [3:0] MV = {1'b0, oam_pkg::OPC_MOV};
  localparam logic [3:0] MB = {1'b1, oam_pkg::OPC_MOV};
  localparam logic [3:0] AD = {1'b0, oam_pkg::OPC_ADD};
  localparam logic [5:0] CL = oam_pkg::OPC_CLR;
  localparam logic [5:0] CM = oam_pkg::OPC_COM;
  localparam logic [5:0] IN = oam_pkg::OPC_INC;

  oam_unit dut (.mclk(mclk), .rst_n(rst_n), .go(go), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_o_q(mem_o_q), .busy_q(busy_q), .done_q(done_q),
    .bad_op_q(bad_op_q));
  oam_mem_model mem (.mclk(mclk), .rst_n(rst_n), .rq(mem_o_q), .ack(mem_ack),
    .rdata(mem_rdata));

  // Free running clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Instruction word builders
  function automatic logic [15:0] two(logic [3:0] op, logic [2:0] sm, logic [2:0] sr,
                                      logic [2:0] dm, logic [2:0] dr);
    return {op, sm, sr, dm, dr};
  endfunction
  function automatic logic [15:0] one(logic b, logic [5:0] op, logic [2:0] dm, logic [2:0] dr);
    return {b, 3'h0, op, dm, dr};
  endfunction

  // Backdoor memory access
  task automatic wr(logic [15:0] a, logic [15:0] v);
    mem.bytes[a] = v[7:0];
    mem.bytes[a + 16'h0001] = v[15:8];
  endtask
  function automatic logic [15:0] rd(logic [15:0] a);
    return {mem.bytes[a + 16'h0001], mem.bytes[a]};
  endfunction
  task automatic put(logic [15:0] w);
    wr(pc, w);
    pc = pc + 16'h0002;
  endtask

  // Comparisons
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(string n, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  // Start one instruction and wait for its end
  task automatic run(logic bad);
    int i;
    @(negedge mclk);
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    chkb("busy", 1'b1, busy_q);
    for (i = 0; i < 300 && done_q !== 1'b1; i++) @(negedge mclk);
    chkb("done", 1'b1, done_q);
    chkb("bad_op", bad, bad_op_q);
    chkb("busy_end", 1'b0, busy_q);
    chkb("req_idle", 1'b0, mem_o_q.req);
  endtask

  // Load a register by immediate move, read one back by absolute store
  task automatic setr(logic [2:0] n, logic [15:0] v);
    put(two(MV, 3'h2, 3'h7, 3'h0, n));
    put(v);
    run(1'b0);
  endtask
  task automatic getr(logic [2:0] n, logic [15:0] e);
    put(two(MV, 3'h0, n, 3'h3, 3'h7));
    put(16'h7F00);
    run(1'b0);
    chk("register", e, rd(16'h7F00));
  endtask

  // Register operands, byte and word
  task automatic s_reg();
    setr(3'h3, 16'h1234);
    put(one(1'b1, CM, 3'h0, 3'h3));
    run(1'b0);
    getr(3'h3, 16'h12CB);
    setr(3'h2, 16'h12FF);
    put(one(1'b1, IN, 3'h0, 3'h2));
    run(1'b0);
    getr(3'h2, 16'h1200);
    setr(3'h4, 16'h0005);
    put(two(AD, 3'h0, 3'h2, 3'h0, 3'h4));
    run(1'b0);
    getr(3'h4, 16'h1205);
    put(two(MB, 3'h0, 3'h3, 3'h0, 3'h4));
    run(1'b0);
    getr(3'h4, 16'h12CB);
  endtask

  // Autoincrement and its deferred form, slow memory
  task automatic s_inc();
    mem.lat = 2;
    setr(3'h5, 16'h4000);
    wr(16'h4000, 16'hAAAA);
    wr(16'h4002, 16'h5555);
    put(one(1'b0, CL, 3'h2, 3'h5));
    run(1'b0);
    chk("word", 16'h0000, rd(16'h4000));
    put(one(1'b1, CL, 3'h2, 3'h5));
    run(1'b0);
    chk("byte", 16'h5500, rd(16'h4002));
    getr(3'h5, 16'h4003);
    setr(3'h6, 16'h4010);
    put(one(1'b1, CL, 3'h2, 3'h6));
    run(1'b0);
    getr(3'h6, 16'h4012);
    setr(3'h2, 16'h4020);
    wr(16'h4020, 16'h4031);
    wr(16'h4030, 16'h0102);
    put(one(1'b1, IN, 3'h3, 3'h2));
    run(1'b0);
    chk("pointed", 16'h0202, rd(16'h4030));
    getr(3'h2, 16'h4022);
    mem.lat = 0;
  endtask

  // Autodecrement and its deferred form
  task automatic s_down();
    setr(3'h0, 16'h4040);
    wr(16'h403E, 16'h1234);
    put(one(1'b1, IN, 3'h4, 3'h0));
    run(1'b0);
    chk("byte", 16'h1334, rd(16'h403E));
    getr(3'h0, 16'h403F);
    setr(3'h6, 16'h4040);
    put(one(1'b1, CL, 3'h4, 3'h6));
    run(1'b0);
    getr(3'h6, 16'h403E);
    setr(3'h1, 16'h4050);
    wr(16'h404E, 16'h4060);
    wr(16'h4060, 16'h00F0);
    put(one(1'b1, CM, 3'h5, 3'h1));
    run(1'b0);
    chk("pointed", 16'h000F, rd(16'h4060));
    put(one(1'b0, CM, 3'h1, 3'h1));
    run(1'b0);
    chk("complement", 16'hBF9F, rd(16'h404E));
    getr(3'h1, 16'h404E);
  endtask

  // Index, index deferred, register deferred, wrap of sums
  task automatic s_idx();
    logic [15:0] xs;
    setr(3'h2, 16'h4100);
    setr(3'h5, 16'h4200);
    wr(16'h4130, 16'h0005);
    wr(16'h4220, 16'h0007);
    put(two(AD, 3'h6, 3'h2, 3'h6, 3'h5));
    xs = pc;
    put(16'h0030);
    put(16'h0020);
    run(1'b0);
    chk("sum", 16'h000C, rd(16'h4220));
    chk("index", 16'h0030, rd(xs));
    getr(3'h2, 16'h4100);
    setr(3'h1, 16'h0022);
    wr(16'h4140, 16'h4300);
    wr(16'h4300, 16'h0011);
    put(two(AD, 3'h7, 3'h2, 3'h0, 3'h1));
    put(16'h0040);
    run(1'b0);
    getr(3'h1, 16'h0033);
    setr(3'h4, 16'hC100);
    wr(16'h4100, 16'hFFFF);
    put(one(1'b0, CL, 3'h6, 3'h4));
    put(16'h8000);
    run(1'b0);
    chk("wrapped", 16'h0000, rd(16'h4100));
    setr(3'h5, 16'h4400);
    wr(16'h4400, 16'hFFFF);
    put(one(1'b0, CL, 3'h1, 3'h5));
    run(1'b0);
    chk("deferred", 16'h0000, rd(16'h4400));
    getr(3'h5, 16'h4400);
  endtask

  // Program counter modes
  task automatic s_pc();
    setr(3'h0, 16'h0001);
    put(two(AD, 3'h2, 3'h7, 3'h0, 3'h0));
    put(16'h00FF);
    run(1'b0);
    getr(3'h0, 16'h0100);
    setr(3'h3, 16'hAB00);
    put(two(MB, 3'h2, 3'h7, 3'h0, 3'h3));
    put(16'h0077);
    run(1'b0);
    getr(3'h3, 16'hAB77);
    wr(16'h4500, 16'h1234);
    put(one(1'b0, CL, 3'h3, 3'h7));
    put(16'h4500);
    run(1'b0);
    chk("absolute", 16'h0000, rd(16'h4500));
    wr(16'h4600, 16'h0041);
    put(one(1'b0, IN, 3'h6, 3'h7));
    put(16'h4600 - (pc + 16'h0002));
    run(1'b0);
    chk("relative", 16'h0042, rd(16'h4600));
    wr(16'h4700, 16'h4702);
    wr(16'h4702, 16'h5555);
    put(one(1'b0, CL, 3'h7, 3'h7));
    put(16'h4700 - (pc + 16'h0002));
    run(1'b0);
    chk("rel_deferred", 16'h0000, rd(16'h4702));
  endtask

  // Specifier order, step wrap, unsupported opcode
  task automatic s_misc();
    setr(3'h2, 16'h4800);
    wr(16'h4800, 16'h1111);
    wr(16'h4802, 16'h2222);
    put(two(MV, 3'h2, 3'h2, 3'h2, 3'h2));
    run(1'b0);
    chk("moved", 16'h1111, rd(16'h4802));
    getr(3'h2, 16'h4804);
    setr(3'h3, 16'hFFFE);
    put(one(1'b0, CL, 3'h2, 3'h3));
    run(1'b0);
    getr(3'h3, 16'h0000);
    put(16'h0AC0);
    run(1'b1);
    getr(3'h3, 16'h0000);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    conclude();
  end

  // Reset then scenarios
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    errors = 0;
    checks_done = 0;
    pc = 16'h0000;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    chkb("busy", 1'b0, busy_q);
    s_reg();
    s_inc();
    s_down();
    s_idx();
    s_pc();
    s_misc();
    conclude();
  end
endmodule // tb_oam_unit
